// ---- hdl/poc_pin_sync.sv ----
// Pin synchroniser: three flops, output moves when the last two agree.
`default_nettype none
module poc_pin_sync (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_pin,
  output logic o_level
);

  logic [2:0] stage_q;
  logic [2:0] stage_d;
  logic level_q;
  logic level_d;

  always_comb begin
    stage_d = {stage_q[1:0], i_pin};
    level_d = (stage_q[1] == stage_q[2]) ? stage_q[2] : level_q;
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      stage_q <= 3'h7;
      level_q <= 1'b1;
    end else begin
      stage_q <= stage_d;
      level_q <= level_d;
    end
  end

  assign o_level = level_q;

endmodule : poc_pin_sync
`default_nettype wire

// ---- hdl/poc_pkg.sv ----
// Constants and types shared by the output and configuration register bank.
`default_nettype none
package poc_pkg;

  // ----------------------------------------------------------------------
  // Register subaddresses
  // ----------------------------------------------------------------------
  localparam logic [7:0] POC_ADDR_UNLOCK = 8'h10;
  localparam logic [7:0] POC_ADDR_OUT_EN = 8'h12;
  localparam logic [7:0] POC_ADDR_CFG1 = 8'h13;
  localparam logic [7:0] POC_ADDR_CFG2 = 8'h14;

  // ----------------------------------------------------------------------
  // Reset values and write masks
  // ----------------------------------------------------------------------
  localparam logic [7:0] POC_RST_OUT_EN = 8'h00;
  localparam logic [7:0] POC_RST_CFG1 = 8'h08;
  localparam logic [7:0] POC_RST_CFG2 = 8'h40;
  localparam logic [7:0] POC_MASK_OUT_EN = 8'h7F;
  localparam logic [7:0] POC_MASK_CFG1 = 8'hFF;
  localparam logic [7:0] POC_MASK_CFG2 = 8'hCF;
  localparam logic [7:0] POC_UNLOCK_READ = 8'h00;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int POC_EN_LINEAR = 0;
  localparam int POC_EN_SW1 = 1;
  localparam int POC_EN_SW2 = 2;
  localparam int POC_EN_SW3 = 3;
  localparam int POC_EN_PIN1 = 4;
  localparam int POC_EN_PIN2 = 5;
  localparam int POC_EN_PIN3 = 6;
  localparam int POC_C1_UVT_LSB = 0;
  localparam int POC_C1_TIGHT = 2;
  localparam int POC_C1_PGD_LSB = 3;
  localparam int POC_C1_ROLE = 5;
  localparam int POC_C1_BUF = 6;
  localparam int POC_C1_PB_LONG = 7;
  localparam int POC_C2_SW2_LIM_LSB = 0;
  localparam int POC_C2_SW3_LIM_LSB = 2;
  localparam int POC_C2_UVH = 6;
  localparam int POC_C2_WARM = 7;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int POC_REF_CLK_HZ = 20_000_000;
  localparam int POC_TICK_MS = 1;
  localparam int POC_TICK_CYCLES = POC_REF_CLK_HZ / 1000 * POC_TICK_MS;
  localparam int POC_PB_SHORT_S = 8;
  localparam int POC_PB_LONG_S = 15;
  localparam logic [13:0] POC_PB_SHORT_TICKS =
    14'(POC_PB_SHORT_S * 1000 / POC_TICK_MS);
  localparam logic [13:0] POC_PB_LONG_TICKS =
    14'(POC_PB_LONG_S * 1000 / POC_TICK_MS);
  localparam int POC_PGD_MS0 = 10;
  localparam int POC_PGD_MS1 = 20;
  localparam int POC_PGD_MS2 = 50;
  localparam int POC_PGD_MS3 = 150;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] data;
  } poc_reg_req_type;

  typedef struct packed {
    logic linear_reg_on;
    logic switch_one_on;
  } poc_seq_type;

endpackage : poc_pkg
`default_nettype wire

// ---- hdl/poc_regs.sv ----
// Protected output enable and configuration registers with their pin logic.
`default_nettype none
module poc_regs
  import poc_pkg::*;
#(
  parameter int TICK_CYCLES = POC_TICK_CYCLES,
  parameter logic [7:0] UNLOCK_KEY = 8'h5A
) (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire poc_reg_req_type i_reg_req,
  input wire logic i_seq_update,
  input wire poc_seq_type i_seq,
  input wire logic i_gen_pin_three,
  input wire logic i_gen_pin_one,
  input wire logic i_push_button_n,
  input wire logic i_power_good_raw,
  output logic [7:0] o_rd_data,
  output logic o_rd_valid,
  output logic o_linear_reg_on,
  output logic o_switch_one_on,
  output logic o_switch_two_on,
  output logic o_switch_three_on,
  output logic o_gen_pin_three_out,
  output logic o_gen_pin_three_oe,
  output logic o_gen_pin_one_out,
  output logic o_gen_pin_one_oe,
  output logic o_gen_out_two_out,
  output logic o_gen_out_two_oe,
  output logic o_buck_pair_warm_reset,
  output logic o_push_button_reset,
  output logic o_power_good,
  output logic o_supervisor_tight,
  output logic [1:0] o_undervolt_threshold,
  output logic o_undervolt_hysteresis,
  output logic [1:0] o_switch_three_limit,
  output logic [1:0] o_switch_two_limit
);

  // ----------------------------------------------------------------------
  // Decoding helpers
  // ----------------------------------------------------------------------
  function automatic logic [7:0] poc_pgd_ticks(input logic [1:0] code);
    case (code)
      2'h0: poc_pgd_ticks = 8'(POC_PGD_MS0 / POC_TICK_MS);
      2'h1: poc_pgd_ticks = 8'(POC_PGD_MS1 / POC_TICK_MS);
      2'h2: poc_pgd_ticks = 8'(POC_PGD_MS2 / POC_TICK_MS);
      default: poc_pgd_ticks = 8'(POC_PGD_MS3 / POC_TICK_MS);
    endcase
  endfunction : poc_pgd_ticks

  function automatic logic poc_is_protected(input logic [7:0] addr);
    poc_is_protected = (addr == POC_ADDR_OUT_EN) ||
      (addr == POC_ADDR_CFG1) || (addr == POC_ADDR_CFG2);
  endfunction : poc_is_protected

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  logic [3:0] pin_raw;
  logic [3:0] pin_s;
  logic pin_three_s, button_s, pg_raw_s, pin_one_s;
  assign pin_raw = {i_gen_pin_one, i_power_good_raw, i_push_button_n,
    i_gen_pin_three};
  assign {pin_one_s, pg_raw_s, button_s, pin_three_s} = pin_s;

  genvar gi;
  for (gi = 0; gi < 4; gi++) begin : g_sync
    poc_pin_sync u_sync (
      .i_ref_clk(i_ref_clk),
      .i_rst(i_rst),
      .i_pin(pin_raw[gi]),
      .o_level(pin_s[gi])
    );
  end

  // ----------------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------------
  logic [7:0] en_q, en_d, cfg1_q, cfg1_d, cfg2_q, cfg2_d;
  logic armed_q, armed_d, rd_valid_q, rd_valid_d;
  logic [7:0] rd_data_q, rd_data_d;
  logic wr_ok;

  assign wr_ok = i_reg_req.wr && armed_q &&
    poc_is_protected(i_reg_req.addr);

  always_comb begin
    en_d = en_q;
    cfg1_d = cfg1_q;
    cfg2_d = cfg2_q;
    armed_d = armed_q;
    rd_valid_d = i_reg_req.rd;
    rd_data_d = 8'h00;
    if (i_reg_req.wr) begin
      armed_d = (i_reg_req.addr == POC_ADDR_UNLOCK) &&
        (i_reg_req.data == UNLOCK_KEY);
    end
    if (wr_ok) begin
      case (i_reg_req.addr)
        POC_ADDR_OUT_EN: en_d = i_reg_req.data & POC_MASK_OUT_EN;
        POC_ADDR_CFG1: cfg1_d = i_reg_req.data & POC_MASK_CFG1;
        POC_ADDR_CFG2: cfg2_d = i_reg_req.data & POC_MASK_CFG2;
        default: en_d = en_q;
      endcase
    end
    // The sequencer wins over a host write in the same cycle.
    if (i_seq_update) begin
      en_d[POC_EN_LINEAR] = i_seq.linear_reg_on;
      en_d[POC_EN_SW1] = i_seq.switch_one_on;
    end
    if (i_reg_req.rd) begin
      case (i_reg_req.addr)
        POC_ADDR_UNLOCK: rd_data_d = POC_UNLOCK_READ;
        POC_ADDR_OUT_EN: rd_data_d = en_q;
        POC_ADDR_CFG1: rd_data_d = cfg1_q;
        POC_ADDR_CFG2: rd_data_d = cfg2_q;
        default: rd_data_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      en_q <= POC_RST_OUT_EN;
      cfg1_q <= POC_RST_CFG1;
      cfg2_q <= POC_RST_CFG2;
      armed_q <= 1'b0;
      rd_valid_q <= 1'b0;
      rd_data_q <= 8'h00;
    end else begin
      en_q <= en_d;
      cfg1_q <= cfg1_d;
      cfg2_q <= cfg2_d;
      armed_q <= armed_d;
      rd_valid_q <= rd_valid_d;
      rd_data_q <= rd_data_d;
    end
  end

  // ----------------------------------------------------------------------
  // Pin drivers
  // ----------------------------------------------------------------------
  logic p3_oe_q, p3_oe_d, p1_oe_q, p1_oe_d, o2_out_q, o2_out_d;
  logic o2_oe_q, o2_oe_d, warm_q, warm_d;
  logic o2_level;

  always_comb begin
    p3_oe_d = !cfg2_q[POC_C2_WARM] && !en_q[POC_EN_PIN3];
    warm_d = cfg2_q[POC_C2_WARM] && !pin_three_s;
    p1_oe_d = !cfg1_q[POC_C1_ROLE] && !en_q[POC_EN_PIN1];
    o2_level = cfg1_q[POC_C1_ROLE] ? pin_one_s : en_q[POC_EN_PIN2];
    // Push-pull high comes from the switch one input supply.
    o2_out_d = cfg1_q[POC_C1_BUF] && o2_level;
    o2_oe_d = cfg1_q[POC_C1_BUF] || !o2_level;
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      p3_oe_q <= 1'b0;
      warm_q <= 1'b0;
      p1_oe_q <= 1'b0;
      o2_out_q <= 1'b0;
      o2_oe_q <= 1'b0;
    end else begin
      p3_oe_q <= p3_oe_d;
      warm_q <= warm_d;
      p1_oe_q <= p1_oe_d;
      o2_out_q <= o2_out_d;
      o2_oe_q <= o2_oe_d;
    end
  end

  // ----------------------------------------------------------------------
  // Millisecond tick, push-button and power-good timers
  // ----------------------------------------------------------------------
  // The tick runs free, so each timed wait is short by up to one tick.
  logic [15:0] div_q, div_d;
  logic tick;
  logic [13:0] pb_cnt_q, pb_cnt_d, pb_limit;
  logic pb_done_q, pb_done_d, pb_rst_q, pb_rst_d;
  logic [7:0] pg_cnt_q, pg_cnt_d;
  logic pg_q, pg_d;

  assign tick = (div_q == 16'(TICK_CYCLES - 1));
  assign pb_limit = cfg1_q[POC_C1_PB_LONG] ? POC_PB_LONG_TICKS
                                           : POC_PB_SHORT_TICKS;

  always_comb begin
    div_d = tick ? 16'h0000 : 16'(div_q + 16'h0001);
    pb_cnt_d = pb_cnt_q;
    pb_done_d = pb_done_q;
    pb_rst_d = 1'b0;
    if (button_s) begin
      pb_cnt_d = 14'h0000;
      pb_done_d = 1'b0;
    end else if (tick && !pb_done_q) begin
      if (pb_cnt_q >= 14'(pb_limit - 14'h0001)) begin
        pb_rst_d = 1'b1;
        pb_done_d = 1'b1;
      end else begin
        pb_cnt_d = 14'(pb_cnt_q + 14'h0001);
      end
    end
    pg_cnt_d = pg_cnt_q;
    pg_d = pg_q;
    if (!pg_raw_s) begin
      pg_d = 1'b0;
      pg_cnt_d = 8'h00;
    end else if (tick && !pg_q) begin
      if (pg_cnt_q >= 8'(poc_pgd_ticks(cfg1_q[POC_C1_PGD_LSB +: 2])
                         - 8'h01)) begin
        pg_d = 1'b1;
      end else begin
        pg_cnt_d = 8'(pg_cnt_q + 8'h01);
      end
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      div_q <= 16'h0000;
      pb_cnt_q <= 14'h0000;
      pb_done_q <= 1'b0;
      pb_rst_q <= 1'b0;
      pg_cnt_q <= 8'h00;
      pg_q <= 1'b0;
    end else begin
      div_q <= div_d;
      pb_cnt_q <= pb_cnt_d;
      pb_done_q <= pb_done_d;
      pb_rst_q <= pb_rst_d;
      pg_cnt_q <= pg_cnt_d;
      pg_q <= pg_d;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign o_rd_data = rd_data_q;
  assign o_rd_valid = rd_valid_q;
  assign o_linear_reg_on = en_q[POC_EN_LINEAR];
  assign o_switch_one_on = en_q[POC_EN_SW1];
  assign o_switch_two_on = en_q[POC_EN_SW2];
  assign o_switch_three_on = en_q[POC_EN_SW3];
  assign o_gen_pin_three_out = 1'b0;
  assign o_gen_pin_three_oe = p3_oe_q;
  assign o_gen_pin_one_out = 1'b0;
  assign o_gen_pin_one_oe = p1_oe_q;
  assign o_gen_out_two_out = o2_out_q;
  assign o_gen_out_two_oe = o2_oe_q;
  assign o_buck_pair_warm_reset = warm_q;
  assign o_push_button_reset = pb_rst_q;
  assign o_power_good = pg_q;
  assign o_supervisor_tight = cfg1_q[POC_C1_TIGHT];
  assign o_undervolt_threshold = cfg1_q[POC_C1_UVT_LSB +: 2];
  assign o_undervolt_hysteresis = cfg2_q[POC_C2_UVH];
  assign o_switch_three_limit = cfg2_q[POC_C2_SW3_LIM_LSB +: 2];
  assign o_switch_two_limit = cfg2_q[POC_C2_SW2_LIM_LSB +: 2];

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);

  enable_write_a: assert property (
    wr_ok && i_reg_req.addr == POC_ADDR_OUT_EN && !i_seq_update |=>
    o_switch_three_on == $past(i_reg_req.data[3]) &&
    o_switch_two_on == $past(i_reg_req.data[2]))
    else $error("switch enables do not follow the write");

  seq_update_a: assert property (
    i_seq_update |=> o_linear_reg_on == $past(i_seq.linear_reg_on) &&
    o_switch_one_on == $past(i_seq.switch_one_on))
    else $error("sequencer update lost");

  pin_three_a: assert property (
    cfg2_q[POC_C2_WARM] |=> !o_gen_pin_three_oe)
    else $error("pin three driven while warm reset owns it");
  pin_one_input_a: assert property (
    cfg1_q[POC_C1_ROLE] |=> !o_gen_pin_one_oe)
    else $error("pin one driven while it is an input");
  pb_hold_a: assert property (
    o_push_button_reset |-> $past(pb_cnt_q) == 14'($past(pb_limit) - 14'h0001))
    else $error("push-button reset at the wrong hold count");
  open_drain_a: assert property (
    !cfg1_q[POC_C1_BUF] |=> !o_gen_out_two_out)
    else $error("open-drain output two driven high");
  out_two_follow_a: assert property (
    cfg1_q[POC_C1_ROLE] && cfg1_q[POC_C1_BUF] |=>
    o_gen_out_two_out == $past(pin_one_s) && o_gen_out_two_oe)
    else $error("output two does not follow pin one");
  pg_fall_a: assert property (
    !pg_raw_s |=> !o_power_good)
    else $error("power good fall was delayed");
  pg_rise_a: assert property (
    $rose(o_power_good) |-> $past(tick) && $past(pg_raw_s))
    else $error("power good rose off the tick");

  warm_reset_a: assert property (
    cfg2_q[POC_C2_WARM] && !pin_three_s |=> o_buck_pair_warm_reset)
    else $error("warm reset not passed to the buck pair");

  limit_write_a: assert property (
    wr_ok && i_reg_req.addr == POC_ADDR_CFG2 |=>
    o_switch_three_limit == $past(i_reg_req.data[3:2]) &&
    o_switch_two_limit == $past(i_reg_req.data[1:0]))
    else $error("current limit codes do not follow the write");

  unlock_read_a: assert property (
    i_reg_req.rd && i_reg_req.addr == POC_ADDR_UNLOCK |=>
    o_rd_valid && o_rd_data == 8'h00)
    else $error("unlock register read back nonzero");

  locked_write_a: assert property (
    i_reg_req.wr && !armed_q && !i_seq_update |=>
    $stable(cfg1_q) && $stable(cfg2_q) && $stable(en_q))
    else $error("protected register changed without unlock");

endmodule : poc_regs
`default_nettype wire

// ---- verif/pmic_output_and_config_regs_bench.sv ----
// Self-checking bench for the output and configuration register bank.
`default_nettype none
module pmic_output_and_config_regs_bench;
  import poc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  // Short tick keeps the push-button counts inside the run length.
  localparam int TICK = 2;
  localparam logic [7:0] KEY = 8'h5A;
  logic clk = 1'b0;
  logic rst = 1'b1;
  poc_reg_req_type req;
  logic seq_upd = 1'b0;
  poc_seq_type seq = '0;
  logic ext_three = 1'b1;
  logic ext_one = 1'b1;
  logic pb_n = 1'b1;
  logic pg_raw = 1'b1;
  logic pin_three, pin_one, rd_valid, lin, sw1, sw2, sw3, warm, pb_rst, pg;
  logic p3_out, p3_oe, p1_out, p1_oe, o2_out, o2_oe, tight, uvh;
  logic [7:0] rd_data;
  logic [1:0] uvt, lim3, lim2;
  int miscompares = 0;
  int checks_done = 0;
  int seed = 96678;
  logic [7:0] exp_q[$];

  // Open-drain pins: the far side sets the level from ext_three and ext_one unless the bank drives.
  assign pin_three = p3_oe ? p3_out : ext_three;
  assign pin_one = p1_oe ? p1_out : ext_one;

  initial forever #25 clk = ~clk;

  poc_host #(.UNLOCK_KEY(KEY)) u_host (.i_ref_clk(clk), .o_req(req));

  poc_regs #(.TICK_CYCLES(TICK), .UNLOCK_KEY(KEY)) u_dut (
    .i_ref_clk(clk), .i_rst(rst), .i_reg_req(req), .i_seq_update(seq_upd),
    .i_seq(seq), .i_gen_pin_three(pin_three), .i_gen_pin_one(pin_one),
    .i_push_button_n(pb_n), .i_power_good_raw(pg_raw),
    .o_rd_data(rd_data), .o_rd_valid(rd_valid), .o_linear_reg_on(lin),
    .o_switch_one_on(sw1), .o_switch_two_on(sw2), .o_switch_three_on(sw3),
    .o_gen_pin_three_out(p3_out), .o_gen_pin_three_oe(p3_oe),
    .o_gen_pin_one_out(p1_out), .o_gen_pin_one_oe(p1_oe),
    .o_gen_out_two_out(o2_out), .o_gen_out_two_oe(o2_oe),
    .o_buck_pair_warm_reset(warm), .o_push_button_reset(pb_rst),
    .o_power_good(pg), .o_supervisor_tight(tight),
    .o_undervolt_threshold(uvt), .o_undervolt_hysteresis(uvh),
    .o_switch_three_limit(lim3), .o_switch_two_limit(lim2));

  // ----------------------------------------------------------------------
  // Checking helpers
  // ----------------------------------------------------------------------
  task automatic fail(input string msg);
    miscompares++;
    $display("Error at %0t: %s", $time, msg);
  endtask : fail

  task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                     input string what);
    checks_done++;
    if (got !== exp) begin
      fail($sformatf("%s got %h expected %h", what, got, exp));
    end
  endtask : chk

  task automatic in_range(input int n, input int lo, input int hi,
                          input string what);
    checks_done++;
    if (n < lo || n > hi) begin
      fail($sformatf("%s took %0d cycles, not %0d..%0d", what, n, lo, hi));
    end
  endtask : in_range

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    u_host.xfer(1'b0, 1'b1, a, 8'h00);
  endtask : rd

  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : end_sim

  // Read data is matched against the oldest expectation on the queue.
  always @(negedge clk) begin
    if (rd_valid === 1'b1) begin
      if (exp_q.size() == 0) begin
        fail("read data with nothing expected");
      end else begin
        chk(rd_data, exp_q.pop_front(), "read data");
      end
    end
  end

  initial begin
    cyc(80000);
    fail("watchdog expired");
    end_sim();
  end

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  initial begin
    logic [7:0] v;
    int n;
    int ms [4];
    ms = '{POC_PGD_MS0, POC_PGD_MS1, POC_PGD_MS2, POC_PGD_MS3};
    cyc(4);
    rst = 1'b0;
    rd(POC_ADDR_OUT_EN, 8'h00);
    rd(POC_ADDR_CFG1, 8'h08);
    rd(POC_ADDR_CFG2, 8'h40);
    rd(POC_ADDR_UNLOCK, 8'h00);
    u_host.xfer(1'b1, 1'b0, POC_ADDR_OUT_EN, 8'h0F);
    rd(POC_ADDR_OUT_EN, 8'h00);
    for (int i = 0; i < 6; i++) begin
      v = 8'($random(seed));
      u_host.prot_write(POC_ADDR_OUT_EN, v);
      rd(POC_ADDR_OUT_EN, v & 8'h7F);
      chk({sw3, sw2, sw1, lin}, v[3:0], "switch enables");
      chk({p3_oe, p3_out}, {~v[6], 1'b0}, "pin three");
      chk({p1_oe, o2_oe, p1_out, o2_out}, {~v[4], ~v[5], 2'b00}, "pins");
    end
    u_host.prot_write(POC_ADDR_OUT_EN, 8'h0F);
    u_host.xfer(1'b1, 1'b0, POC_ADDR_OUT_EN, 8'h00);
    rd(POC_ADDR_OUT_EN, 8'h0F);
    for (int k = 0; k < 4; k++) begin
      @(negedge clk);
      seq_upd = 1'b1;
      seq = poc_seq_type'(k[1:0]);
      @(negedge clk);
      seq_upd = 1'b0;
      rd(POC_ADDR_OUT_EN, {6'h03, k[0], k[1]});
      chk({sw1, lin}, {k[0], k[1]}, "sequencer bits");
    end
    u_host.prot_write(POC_ADDR_CFG1, 8'h48);
    u_host.prot_write(POC_ADDR_OUT_EN, 8'h20);
    cyc(2);
    chk({o2_oe, o2_out}, 2'b11, "push-pull high");
    u_host.prot_write(POC_ADDR_OUT_EN, 8'h00);
    cyc(2);
    chk({o2_oe, o2_out}, 2'b10, "push-pull low");
    // Pin one as input, with output two first open-drain, then push-pull.
    for (int k = 0; k < 4; k++) begin
      u_host.prot_write(POC_ADDR_CFG1, {1'b0, k[1], 6'h28});
      ext_one = k[0];
      cyc(8);
      chk(p1_oe, 1'b0, "pin one released");
      chk({o2_oe, o2_out}, {k[1] | !k[0], k[1] & k[0]}, "out two");
    end
    u_host.prot_write(POC_ADDR_CFG2, 8'h80);
    for (int k = 0; k < 2; k++) begin
      ext_three = k[0];
      cyc(8);
      chk(p3_oe, 1'b0, "pin three released");
      chk(warm, !k[0], "warm reset");
    end
    for (int i = 0; i < 4; i++) begin
      v = 8'($random(seed)) & 8'h7F;
      u_host.prot_write(POC_ADDR_CFG2, v);
      rd(POC_ADDR_CFG2, v & 8'hCF);
      chk({uvh, lim3, lim2}, {v[6], v[3:0]}, "limit fields");
    end
    u_host.prot_write(POC_ADDR_CFG1, 8'h0D);
    cyc(1);
    chk({tight, uvt}, 3'b101, "supervisor fields");
    // Delay is measured from the raw rise; sync and tick phase add slack.
    for (int c = 0; c < 4; c++) begin
      u_host.prot_write(POC_ADDR_CFG1, {3'b000, c[1:0], 3'b000});
      pg_raw = 1'b0;
      cyc(10);
      chk(pg, 1'b0, "power good fall");
      pg_raw = 1'b1;
      n = 0;
      while (pg !== 1'b1 && n < 1000) begin
        cyc(1);
        n++;
      end
      in_range(n, (ms[c] - 1) * TICK, ms[c] * TICK + 10, "pg rise");
    end
    for (int l = 0; l < 2; l++) begin
      u_host.prot_write(POC_ADDR_CFG1, {l[0], 7'h08});
      v = 8'h00;
      pb_n = 1'b0;
      n = 0;
      while (pb_rst !== 1'b1 && n < 40000) begin
        cyc(1);
        n++;
      end
      v = l ? 8'd15 : 8'd8;
      in_range(n, (int'(v) * 1000 - 1) * TICK, int'(v) * 1000 * TICK + 10,
               "push-button hold");
      pb_n = 1'b1;
      cyc(10);
    end
    cyc(4);
    chk(8'(exp_q.size()), 8'h00, "reads left unanswered");
    end_sim();
  end
endmodule : pmic_output_and_config_regs_bench
`default_nettype wire

// ---- verif/poc_host.sv ----
// Host model that issues requests on the register port of the bank.
`default_nettype none
module poc_host
  import poc_pkg::*;
#(
  parameter logic [7:0] UNLOCK_KEY = 8'h5A
) (
  input wire logic i_ref_clk,
  output var poc_reg_req_type o_req
);
  timeunit 1ns;
  timeprecision 1ps;

  initial o_req = '0;

  // One request per call, held one clock and then withdrawn, so the
  // bank never sees a request twice.
  task automatic xfer(input logic wr, input logic rd, input logic [7:0] a,
                      input logic [7:0] d);
    @(negedge i_ref_clk);
    o_req = '{wr: wr, rd: rd, addr: a, data: d};
    @(negedge i_ref_clk);
    o_req = '0;
  endtask : xfer

  // The key write always comes straight before the protected write.
  task automatic prot_write(input logic [7:0] a, input logic [7:0] d);
    xfer(1'b1, 1'b0, POC_ADDR_UNLOCK, UNLOCK_KEY);
    xfer(1'b1, 1'b0, a, d);
  endtask : prot_write
endmodule : poc_host
`default_nettype wire
